/* design/ccdfe_pkg.sv */
// Purpose: shared constants and types of the front-end clamp and output timing block
// Assumes: APB word registers at byte address = index * 4
// Notes: black maps to the clamp target after correction
package ccdfe_pkg;
   localparam int DW = 10;
   // register indices, byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'h000;
   localparam logic [11:0] IDX_STAT = 12'h001;
   localparam logic [11:0] IDX_DUMMY = 12'h0F7;
   localparam logic [11:0] CTRL_RST = 12'h001;
   localparam logic [4:0] DUMMY_RST = 5'h00;
   // field positions
   localparam int DC_OFS_LSB = 10;
   localparam int DC_SCL_LSB = 8;
   localparam int ST_DUMMY_BIT = 16;
   localparam int ST_WIN_BIT = 17;
   // offset codes and offsets in LSB
   localparam logic [2:0] OFS_OFF = 3'h0;
   localparam logic [2:0] OFS_C32 = 3'h1;
   localparam logic [2:0] OFS_C64 = 3'h2;
   localparam logic [2:0] OFS_C96 = 3'h3;
   localparam logic [2:0] OFS_C224 = 3'h7;
   localparam logic [7:0] OFS_V32 = 8'h20;
   localparam logic [7:0] OFS_V64 = 8'h40;
   localparam logic [7:0] OFS_V96 = 8'h60;
   localparam logic [7:0] OFS_V224 = 8'hE0;
   // levels
   localparam logic [9:0] CLAMP_TARGET = 10'h040;
   localparam logic [9:0] BLK_MAX = 10'h0C0;
   localparam logic [9:0] CLAMP_RST = 10'h040;
   // timing in conversion-clock cycles, then the base feedback shift
   localparam logic [3:0] OB_WIN_FIRST = 4'h5;
   localparam logic [3:0] OB_WIN_LAST = 4'hC;
   localparam int LAT_CDS = 10;
   localparam int LAT_DIR = 9;
   localparam logic [2:0] SCL_BASE_SHIFT = 3'h2;
   typedef struct packed {
      logic [3:0] gain;
      logic lowPower;
      logic [1:0] holdAmpBw;
      logic [3:0] rcSel;
      logic modeCds;
   } ccdfe_ctrl_type;
   typedef struct packed {
      logic [2:0] ofs;
      logic [1:0] scl;
   } ccdfe_dummy_type;
endpackage : ccdfe_pkg

/* design/ccdfe_top.sv */
// Purpose: output pipeline, black window, averaging clamp and dummy clamp of a sensor front end
// Assumes: sampleIn is the converted code, pins are asynchronous to clock
// Notes: sample is taken at the edge that loads the first input stage
// Operation
// - output word launched on conversion clock edge
// - correlated mode latency ten cycles
// - direct mode latency nine cycles
// - direct mode captures input on rising edge
// - black window cycles five to twelve
// - eight-sample black average is clamp level
// - offset field decodes off,32,64,96,224
// - feedback scale 1/4..1/32 only while dummy
// - out-of-range black switches to dummy clamp
// - dummy offset scales with amplifier gain
// - four-bit hold time-constant select
// - preblank holds output at clamp code
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module ccdfe_top
   import ccdfe_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DW-1:0] sampleIn,
   input wire logic opticalBlackPulse,
   input wire logic preblankInput,
   output logic [DW-1:0] dataOut,
   output logic [3:0] blackHoldRcSelect,
   output logic [1:0] holdAmplifierBw,
   output logic lowPowerSelect,
   output logic [2:0] clampFeedbackShift,
   output logic dummyClampActive
);
   logic [DW-1:0] pipe_r [0:LAT_CDS-1];
   logic [DW-1:0] rawTap_r;
   logic [DW-1:0] dataOut_r;
   logic [1:0] obSync_r;
   logic [1:0] pbSync_r;
   logic obPrev_r;
   logic [3:0] obCnt_r;
   logic [12:0] acc_r;
   logic [9:0] clampRef_r;
   logic dummyActive_r;
   logic [2:0] fbShift_r;
   ccdfe_ctrl_type ctrl_r;
   ccdfe_dummy_type dummy_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [3:0] fillCnt_r;

   logic [DW-1:0] tap;
   logic obRise;
   logic obWin;
   logic preblank_input;
   logic [12:0] accNxt;
   logic [9:0] avgNxt;
   logic [7:0] ofsLsb;
   logic [12:0] ofsProd;
   logic [9:0] dummyRef;
   logic signed [12:0] corr;
   logic signed [12:0] diff;
   logic signed [12:0] step;
   logic [DW-1:0] corrOut;
   logic [11:0] regIdx;
   logic access;
   logic hit;

   // conversion pipeline: stages 0 and 1 also synchronise the pin
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < LAT_CDS; i++) begin
            pipe_r[i] <= '0;
         end
      end else begin
         pipe_r[0] <= sampleIn;
         for (int i = 1; i < LAT_CDS; i++) begin
            pipe_r[i] <= pipe_r[i-1];
         end
      end
   end

   // edges since reset release; latency checks must not look back past the flush
   always_ff @(posedge clock) begin
      if (srst) begin
         fillCnt_r <= '0;
      end else if (fillCnt_r != 4'(LAT_CDS)) begin
         fillCnt_r <= fillCnt_r + 4'h1;
      end
   end

   // tap chosen so the word reaches the pins LAT_CDS or LAT_DIR edges after capture
   assign tap = ctrl_r.modeCds ? pipe_r[LAT_CDS-1] : pipe_r[LAT_DIR-1];

   always_comb begin
      corr = $signed({3'h0, tap}) + $signed({3'h0, CLAMP_TARGET}) - $signed({3'h0, clampRef_r});
      if (corr < 0) begin
         corrOut = '0;
      end else if (corr > 13'sh03FF) begin
         corrOut = 10'h3FF;
      end else begin
         corrOut = corr[DW-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rawTap_r <= '0;
         dataOut_r <= '0;
      end else begin
         rawTap_r <= tap;
         if (preblank_input) begin
            dataOut_r <= CLAMP_TARGET;
         end else begin
            dataOut_r <= corrOut;
         end
      end
   end

   // pin synchronisers for the black pulse and preblank
   always_ff @(posedge clock) begin
      if (srst) begin
         obSync_r <= '0;
         pbSync_r <= '0;
         obPrev_r <= 1'b0;
      end else begin
         obSync_r <= {obSync_r[0], opticalBlackPulse};
         pbSync_r <= {pbSync_r[0], preblankInput};
         obPrev_r <= obSync_r[1];
      end
   end

   assign preblank_input = pbSync_r[1];
   assign obRise = obSync_r[1] & ~obPrev_r;
   assign obWin = (obCnt_r >= OB_WIN_FIRST) && (obCnt_r <= OB_WIN_LAST);

   // window counter; a pulse while counting is ignored
   always_ff @(posedge clock) begin
      if (srst) begin
         obCnt_r <= '0;
      end else if (obCnt_r == 4'h0) begin
         if (obRise) begin
            obCnt_r <= 4'h1;
         end
      end else if (obCnt_r == OB_WIN_LAST) begin
         obCnt_r <= 4'h0;
      end else begin
         obCnt_r <= obCnt_r + 4'h1;
      end
   end

   // black samples are not taken while the input is blanked
   assign accNxt = acc_r + (preblank_input ? 13'h0000 : {3'h0, pipe_r[1]});
   assign avgNxt = accNxt[12:3];

   always_ff @(posedge clock) begin
      if (srst) begin
         acc_r <= '0;
      end else if (obWin && obCnt_r != OB_WIN_LAST) begin
         acc_r <= accNxt;
      end else begin
         acc_r <= '0;
      end
   end

   always_comb begin
      case (dummy_r.ofs)
         OFS_C32: ofsLsb = OFS_V32;
         OFS_C64: ofsLsb = OFS_V64;
         OFS_C96: ofsLsb = OFS_V96;
         OFS_C224: ofsLsb = OFS_V224;
         default: ofsLsb = 8'h00;
      endcase
   end

   assign ofsProd = ofsLsb * {1'b1, ctrl_r.gain};
   assign dummyRef = CLAMP_TARGET + {1'b0, ofsProd[12:4]};
   assign diff = $signed({3'h0, dummyRef}) - $signed({3'h0, clampRef_r});
   assign step = diff >>> (SCL_BASE_SHIFT + {1'b0, dummy_r.scl});

   // clamp reference updates once per window end
   always_ff @(posedge clock) begin
      if (srst) begin
         clampRef_r <= CLAMP_RST;
         dummyActive_r <= 1'b0;
         fbShift_r <= '0;
      end else if (obCnt_r == OB_WIN_LAST) begin
         if (avgNxt > BLK_MAX) begin
            dummyActive_r <= 1'b1;
            fbShift_r <= SCL_BASE_SHIFT + {1'b0, dummy_r.scl};
            clampRef_r <= 10'(clampRef_r + step[9:0]);
         end else begin
            dummyActive_r <= 1'b0;
            fbShift_r <= '0;
            clampRef_r <= avgNxt;
         end
      end
   end

   // APB slave, one wait state per access
   assign regIdx = paddr[13:2];
   assign access = psel & penable & ~pready_r;
   assign hit = (regIdx == IDX_CTRL) || (regIdx == IDX_STAT) || (regIdx == IDX_DUMMY);

   always_ff @(posedge clock) begin
      if (srst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= access;
         pslverr_r <= access & ~hit;
         prdata_r <= '0;
         if (access && !pwrite) begin
            case (regIdx)
               IDX_CTRL: prdata_r <= {20'h00000, ctrl_r};
               IDX_STAT: prdata_r <= {14'h0000, (obCnt_r != 4'h0), dummyActive_r, 6'h00, clampRef_r};
               IDX_DUMMY: prdata_r <= {19'h00000, dummy_r, 8'h00};
               default: prdata_r <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_r <= CTRL_RST;
         dummy_r <= DUMMY_RST;
      end else if (psel && penable && pready_r && pwrite) begin
         if (regIdx == IDX_CTRL) begin
            ctrl_r <= pwdata[11:0];
         end
         if (regIdx == IDX_DUMMY) begin
            dummy_r <= pwdata[DC_OFS_LSB+2:DC_SCL_LSB];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         blackHoldRcSelect <= '0;
         holdAmplifierBw <= '0;
         lowPowerSelect <= 1'b0;
      end else begin
         blackHoldRcSelect <= ctrl_r.rcSel;
         holdAmplifierBw <= ctrl_r.holdAmpBw;
         lowPowerSelect <= ctrl_r.lowPower;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign dataOut = dataOut_r;
   assign clampFeedbackShift = fbShift_r;
   assign dummyClampActive = dummyActive_r;

   a_cds_latency: assert property (@(posedge clock) disable iff (srst)
      (fillCnt_r == 4'(LAT_CDS) && $past(ctrl_r.modeCds)) |-> rawTap_r == $past(pipe_r[0], 10))
      else $error("correlated mode latency wrong");
   a_dir_latency: assert property (@(posedge clock) disable iff (srst)
      (fillCnt_r == 4'(LAT_CDS) && !$past(ctrl_r.modeCds)) |-> rawTap_r == $past(pipe_r[0], 9))
      else $error("direct mode latency wrong");
   a_out_launch: assert property (@(posedge clock) disable iff (srst)
      (!$past(preblank_input) && $past(clampRef_r) == CLAMP_TARGET) |-> dataOut_r == rawTap_r)
      else $error("output word not launched from tap");
   a_input_capture: assert property (@(posedge clock) disable iff (srst)
      fillCnt_r >= 4'h2 |-> pipe_r[1] == $past(sampleIn, 2))
      else $error("input capture stage wrong");
   a_window_span: assert property (@(posedge clock) disable iff (srst)
      (obRise && obCnt_r == 4'h0) |=> !obWin [*4] ##1 obWin [*8] ##1 !obWin)
      else $error("black window misplaced");
   a_black_average: assert property (@(posedge clock) disable iff (srst)
      (obCnt_r == OB_WIN_LAST && avgNxt <= BLK_MAX) |=> clampRef_r == $past(avgNxt) && !dummyActive_r)
      else $error("clamp level not the window average");
   a_dummy_switch: assert property (@(posedge clock) disable iff (srst)
      (obCnt_r == OB_WIN_LAST && avgNxt > BLK_MAX) |=> dummyActive_r && fbShift_r >= 3'h2)
      else $error("dummy clamp not entered");
   a_offset_decode: assert property (@(posedge clock) disable iff (srst)
      dummy_r.ofs == OFS_C224 |-> ofsLsb == 8'hE0)
      else $error("offset decode wrong");
   a_reserved_off: assert property (@(posedge clock) disable iff (srst)
      (dummy_r.ofs[2] && dummy_r.ofs != OFS_C224) |-> ofsLsb == 8'h00)
      else $error("reserved offset not off");
   a_preblank_code: assert property (@(posedge clock) disable iff (srst)
      $past(preblank_input) |-> dataOut_r == CLAMP_TARGET)
      else $error("preblank output not clamp code");
   a_gain_scale: assert property (@(posedge clock) disable iff (srst)
      dummy_r.ofs == OFS_C224 |-> dummyRef >= CLAMP_TARGET + 10'h0E0)
      else $error("dummy offset not scaled by gain");
   a_scale_dummy_only: assert property (@(posedge clock) disable iff (srst)
      !dummyActive_r |-> fbShift_r == 3'h0)
      else $error("feedback reduced outside dummy clamp");
   a_hold_select: assert property (@(posedge clock) disable iff (srst)
      blackHoldRcSelect == $past(ctrl_r.rcSel) && lowPowerSelect == $past(ctrl_r.lowPower))
      else $error("hold select output not following register");
endmodule : ccdfe_top

/* verif/ccdfe_sensor_model.sv */
// Purpose: sensor side of the front end: pixel level, black pulse, preblank
// Assumes: bench changes level, blank and obpReq right after a rising edge
// Notes: black pulse lasts one cycle per request
`timescale 1ns/1ps
module ccdfe_sensor_model
   import ccdfe_pkg::*;
(
   input wire logic clock,
   input wire logic [DW-1:0] level,
   input wire logic blank,
   input wire logic obpReq,
   output logic [DW-1:0] sampleIn,
   output logic opticalBlackPulse,
   output logic preblankInput
);
   // a swamped pixel during blanking shows garbage so isolation is seen
   assign sampleIn = blank ? ~level : level;
   assign preblankInput = blank;
   always_ff @(posedge clock) begin
      opticalBlackPulse <= obpReq;
   end
endmodule : ccdfe_sensor_model

/* verif/test_ccdfe_top.sv */
// Purpose: self-checking bench of the clamp and output timing block
// Assumes: one APB answer per request, dataOut checked at negedge by due cycle
// Notes: driver notes expectations in queues, monitor compares
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t %0h %0h", $time, (g), (e)); end end
module test_ccdfe_top;
   import ccdfe_pkg::*;
   logic clock = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] seed = 32'h0000EEBF;
   logic [31:0] r;
   logic pready, pslverr, opticalBlackPulse, preblankInput, lowPowerSelect, dummyClampActive;
   logic [DW-1:0] level = 10'h0;
   logic blank = 1'h0;
   logic obpReq = 1'h0;
   logic [DW-1:0] sampleIn, dataOut;
   logic [3:0] blackHoldRcSelect;
   logic [1:0] holdAmplifierBw;
   logic [2:0] clampFeedbackShift;
   logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   int clampRef = 64;
   int gain = 0;
   int tgt = 0;
   logic [7:0] ofsv [8] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h00, 8'h00, 8'h00, 8'hE0};
   int dueQ [$];
   logic [DW-1:0] valQ [$];
   logic [33:0] rdQ [$];
   initial begin
      forever #12.5 clock = ~clock;
   end
   ccdfe_sensor_model i_ccdfe_sensor_model (.clock(clock), .level(level), .blank(blank), .obpReq(obpReq),
      .sampleIn(sampleIn), .opticalBlackPulse(opticalBlackPulse), .preblankInput(preblankInput));
   ccdfe_top i_ccdfe_top (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sampleIn(sampleIn), .opticalBlackPulse(opticalBlackPulse), .preblankInput(preblankInput),
      .dataOut(dataOut), .blackHoldRcSelect(blackHoldRcSelect), .holdAmplifierBw(holdAmplifierBw),
      .lowPowerSelect(lowPowerSelect), .clampFeedbackShift(clampFeedbackShift),
      .dummyClampActive(dummyClampActive));
   function automatic logic [31:0] xrand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xrand
   function automatic logic [DW-1:0] corr(input int s);
      int v;
      v = s + 64 - clampRef;
      return (v < 0) ? 10'h0 : (v > 1023) ? 10'h3FF : v[DW-1:0];
   endfunction : corr
   task automatic test_done();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   always @(negedge clock) begin
      cyc++;
      if (dueQ.size() > 0 && dueQ[0] == cyc) begin
         `CHK(dataOut, valQ[0])
         void'(dueQ.pop_front());
         void'(valQ.pop_front());
      end
      if (pready === 1'h1 && rdQ.size() > 0) begin
         if (rdQ[0][33]) `CHK(prdata, rdQ[0][31:0])
         `CHK(pslverr, rdQ[0][32])
         void'(rdQ.pop_front());
      end
   end
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd, input logic [32:0] e);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      rdQ.push_back({!wr, e});
      @(posedge clock);
      penable <= 1'h1;
      for (int i = 0; i <= 20; i++) begin
         @(negedge clock);
         if (pready === 1'h1) break;
         if (i == 20) begin
            errors++;
            test_done();
         end
      end
      @(posedge clock);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // lat 0 streams expect nothing unless blanked, used to flush the pipe
   task automatic stream(input int n, input int lat, input logic rnd, input logic [9:0] fv, input logic bl);
      logic [31:0] x;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         x = rnd ? xrand() : {22'h0, fv};
         level <= x[9:0];
         blank <= bl;
         if (bl && i >= 5) begin
            dueQ.push_back(cyc + 1);
            valQ.push_back(CLAMP_TARGET);
         end else if (!bl && lat > 0) begin
            dueQ.push_back(cyc + 2 + lat);
            valQ.push_back(corr(x[9:0]));
         end
      end
   endtask : stream
   task automatic window(input logic [9:0] b);
      @(posedge clock);
      obpReq <= 1'h1;
      level <= b;
      @(posedge clock);
      obpReq <= 1'h0;
      stream(30, 0, 1'h0, b, 1'h0);
   endtask : window
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'h0;
      apb(1'h0, IDX_CTRL, 32'h0, {21'h0, CTRL_RST});
      apb(1'h0, IDX_DUMMY, 32'h0, 33'h0);
      apb(1'h0, IDX_STAT, 32'h0, {23'h0, CLAMP_RST});
      apb(1'h0, 12'h0F0, 32'h0, 33'h100000000);
      apb(1'h1, 12'h0F0, 32'hFFFF, 33'h100000000);
      stream(40, LAT_CDS, 1'h1, 10'h0, 1'h0);
      stream(15, 0, 1'h0, 10'h0, 1'h0);
      stream(30, 0, 1'h1, 10'h0, 1'h1);
      stream(15, 0, 1'h0, 10'h0, 1'h0);
      window(10'h050);
      clampRef = 80;
      apb(1'h1, IDX_STAT, 32'h3FF, 33'h0);
      apb(1'h0, IDX_STAT, 32'h0, {23'h0, 10'h050});
      `CHK(dummyClampActive, 1'h0)
      `CHK(clampFeedbackShift, 3'h0)
      r = xrand();
      r[0] = 1'h0;
      gain = int'(r[11:8]);
      apb(1'h1, IDX_CTRL, r, 33'h0);
      apb(1'h0, IDX_CTRL, 32'h0, {21'h0, r[11:0]});
      `CHK(blackHoldRcSelect, r[4:1])
      `CHK({lowPowerSelect, holdAmplifierBw}, r[7:5])
      stream(40, LAT_DIR, 1'h1, 10'h0, 1'h0);
      for (int k = 0; k < 8; k++) begin
         r = xrand();
         r[12:8] = {codes[k], k[1:0]};
         apb(1'h1, IDX_DUMMY, r, 33'h0);
         apb(1'h0, IDX_DUMMY, 32'h0, {20'h0, r[12:8], 8'h0});
         window(10'h1F0);
         `CHK(dummyClampActive, 1'h1)
         `CHK(clampFeedbackShift, 3'h2 + {1'h0, k[1:0]})
         tgt = 64 + ((ofsv[codes[k]] * (16 + gain)) >>> 4);
         clampRef = clampRef + ((tgt - clampRef) >>> (2 + k % 4));
         apb(1'h0, IDX_STAT, 32'h0, {15'h0, 2'h1, 6'h0, clampRef[9:0]});
      end
      test_done();
   end
endmodule : test_ccdfe_top
